/* File: hdl/irwd_decoder.sv */
// Purpose: infrared remote wake-up decoder, bi-phase and pulse-distance
// Assumes: CLOCK at 25 MHz, receiver inputs asynchronous to CLOCK
// Notes:   decoded line level high means carrier burst present
//
// Function
// - control register resets to zero: bi-phase, input a, no invert, off.
// - control bit 3 picks receiver input b instead of input a.
// - control bit 2 inverts the chosen input before decoding.
// - enable bit 0 low keeps registers but blocks event status.
// - outer wake enable never gates the infrared event status.
// - enabled and address match under mask sets status bit 5.
// - address bits compare only where the mask bit is zero.
// - address mask resets to e0h, upper three bits ignored.
// - received address shifts into read-only register reset to zero.
// - all range limits count in units of 0.1 ms.
// - bi-phase full bit cell must fall in range 0, reset 10h/14h.
// - pulse-distance spacing in range 0 decodes a zero.
// - bi-phase half cell must fall in range 1, reset 07h/0bh.
// - pulse-distance spacing in range 1 decodes a one.
// - pulse-distance header pulse must fall in range 2.
// - pulse-distance post-header gap must fall in range 3.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module irwd_decoder
  import irwd_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  input  wire logic       CLK_EN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       IR_RECEIVE_INPUT_A,
  input  wire logic       IR_RECEIVE_INPUT_B,
  output logic            IRQ,
  output logic            WAKE_MATCH
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PD_HEADER,
    ST_PD_GAP,
    ST_PD_BITS,
    ST_BIPHASE
  } irwd_state_t;

  // software-visible registers
  irwd_ctrl_t  ir_wake_control;
  logic [7:0]  ir_wake_address;
  logic [7:0]  ir_wake_address_mask;
  logic [7:0]  ir_received_address;
  logic [4:0]  r0_low;
  logic [4:0]  r0_high;
  logic [4:0]  r1_low;
  logic [4:0]  r1_high;
  irwd_range_t range2;
  irwd_range_t range3;
  logic [7:0]  event_status;
  logic [7:0]  event_mask;

  // receiver path
  logic [1:0]  sync_a;
  logic [1:0]  sync_b;
  logic        ir_level;
  logic        ir_prev;
  logic        edge_any;
  logic        edge_rise;
  logic        ir_receive_input_selected;
  logic        ctrl_written;

  // time base and interval counters
  logic [15:0] tick_cnt;
  logic        tick;
  logic [7:0]  lvl_cnt;
  logic [7:0]  rise_cnt;

  // frame decoder and status
  irwd_state_t state;
  logic [4:0]  half_pos;
  logic [5:0]  bit_cnt;
  logic        frame_done;
  logic        addr_match;
  logic        in_r0_lvl;
  logic        in_r1_lvl;
  logic        in_r0_rise;
  logic        in_r1_rise;
  logic        bip_full;
  logic [4:0]  next_half_pos;
  logic [7:0]  set_bits;
  logic [7:0]  clr_bits;
  logic        wr_hit;

  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // two-flop synchronisers, one per receiver input
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
    end else if (CLK_EN) begin
      sync_a <= {sync_a[0], IR_RECEIVE_INPUT_A};
      sync_b <= {sync_b[0], IR_RECEIVE_INPUT_B};
    end
  end

  // input pick and polarity, read only from second flops
  assign ir_receive_input_selected = ir_wake_control.sel_b ? sync_b[1] : sync_a[1];
  assign ir_level = ir_receive_input_selected ^ ir_wake_control.invert;
  // a control write can flip the level by itself, so that cycle is no receiver edge;
  // a true edge landing in the very same cycle is lost, a rare and harmless trade
  assign edge_any  = ir_level != ir_prev && !ctrl_written;
  assign edge_rise = ir_level && !ir_prev && !ctrl_written;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ctrl_written <= 1'b0;
    end else if (CLK_EN) begin
      ctrl_written <= REG_WR && REG_ADDR == OFS_CONTROL;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ir_prev <= 1'b0;
    end else if (CLK_EN) begin
      ir_prev <= ir_level;
    end
  end

  // 0.1 ms time base
  assign tick = tick_cnt == 16'(TICK_LEN - 1);

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      tick_cnt <= 16'h0000;
    end else if (CLK_EN) begin
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // interval counters saturate so a long idle never wraps into a valid range
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      lvl_cnt  <= 8'h00;
      rise_cnt <= 8'h00;
    end else if (CLK_EN) begin
      if (edge_any) begin
        lvl_cnt <= 8'h00;
      end else if (tick && lvl_cnt != 8'hff) begin
        lvl_cnt <= lvl_cnt + 8'h01;
      end
      if (edge_rise) begin
        rise_cnt <= 8'h00;
      end else if (tick && rise_cnt != 8'hff) begin
        rise_cnt <= rise_cnt + 8'h01;
      end
    end
  end

  // range classification of the interval just ended
  assign in_r0_lvl  = in_range(lvl_cnt, {3'h0, r0_low}, {3'h0, r0_high});
  assign in_r1_lvl  = in_range(lvl_cnt, {3'h0, r1_low}, {3'h0, r1_high});
  assign in_r0_rise = in_range(rise_cnt, {3'h0, r0_low}, {3'h0, r0_high});
  assign in_r1_rise = in_range(rise_cnt, {3'h0, r1_low}, {3'h0, r1_high});
  assign bip_full   = in_r0_lvl && !in_r1_lvl;
  assign next_half_pos = half_pos + (bip_full ? 5'h02 : 5'h01);

  // frame decoder; a reserved protocol code leaves it idle
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state               <= ST_IDLE;
      half_pos            <= 5'h00;
      bit_cnt             <= 6'h00;
      frame_done          <= 1'b0;
      ir_received_address <= RST_RECV_ADDR;
    end else if (CLK_EN) begin
      frame_done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (edge_rise && ir_wake_control.proto == PROTO_PULSEDIS) begin
            state               <= ST_PD_HEADER;
            ir_received_address <= 8'h00;
          end else if (edge_rise && ir_wake_control.proto == PROTO_BIPHASE) begin
            // first rise is the middle of the first start bit
            state               <= ST_BIPHASE;
            half_pos            <= 5'h01;
            ir_received_address <= 8'h00;
          end
        end
        ST_PD_HEADER: begin
          if (edge_any) begin
            state <= in_range(lvl_cnt, range2.low, range2.high) ? ST_PD_GAP : ST_IDLE;
          end
        end
        ST_PD_GAP: begin
          if (edge_any) begin
            bit_cnt <= 6'h00;
            state   <= in_range(lvl_cnt, range3.low, range3.high) ? ST_PD_BITS : ST_IDLE;
          end
        end
        ST_PD_BITS: begin
          if (edge_rise) begin
            if (!in_r0_rise && !in_r1_rise) begin
              state <= ST_IDLE;
            end else begin
              // range 0 wins if software makes the ranges overlap
              if (bit_cnt < PD_ADDR_BITS) begin
                ir_received_address <= {!in_r0_rise, ir_received_address[7:1]};
              end
              bit_cnt <= bit_cnt + 6'h01;
              if (bit_cnt == PD_LAST_BIT) begin
                state      <= ST_IDLE;
                frame_done <= 1'b1;
              end
            end
          end else if (lvl_cnt == 8'hff) begin
            state <= ST_IDLE;
          end
        end
        ST_BIPHASE: begin
          if (edge_any) begin
            // a full cell may only start at a mid-bit edge
            if ((!in_r0_lvl && !in_r1_lvl) || (bip_full && !half_pos[0])) begin
              state <= ST_IDLE;
            end else begin
              half_pos <= next_half_pos;
              if (next_half_pos[0]) begin
                if (next_half_pos[4:1] >= BIP_ADDR_FIRST[3:0] &&
                    next_half_pos[4:1] <= BIP_ADDR_LAST[3:0]) begin
                  ir_received_address <= {ir_received_address[6:0], ir_level};
                end
                if (next_half_pos[4:1] == BIP_LAST_BIT[3:0]) begin
                  state      <= ST_IDLE;
                  frame_done <= 1'b1;
                end
              end
            end
          end else if (lvl_cnt == 8'hff) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // masked compare of captured and programmed address
  assign addr_match = ((ir_received_address ^ ir_wake_address) & ~ir_wake_address_mask) == 8'h00;

  // only the decoder enable gates the status, no outer enable exists here
  always_comb begin
    set_bits = 8'h00;
    set_bits[BIT_FRAME_DONE] = frame_done && ir_wake_control.enable;
    set_bits[BIT_WAKE_MATCH] = frame_done && ir_wake_control.enable && addr_match;
    clr_bits = (REG_WR && REG_ADDR == OFS_EVENT_STATUS) ? REG_WDATA : 8'h00;
  end

  // sticky status: a set in the clearing cycle survives
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      event_status <= 8'h00;
      IRQ          <= 1'b0;
      WAKE_MATCH   <= 1'b0;
    end else if (CLK_EN) begin
      event_status <= (event_status & ~clr_bits) | set_bits;
      IRQ          <= |(((event_status & ~clr_bits) | set_bits) & event_mask);
      WAKE_MATCH   <= set_bits[BIT_WAKE_MATCH];
    end
  end

  // register writes; reserved bits are not stored
  assign wr_hit = REG_WR;

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ir_wake_control      <= irwd_ctrl_t'(RST_CONTROL);
      ir_wake_address      <= RST_WAKE_ADDR;
      ir_wake_address_mask <= RST_ADDR_MASK;
      r0_low               <= RST_R0_LOW;
      r0_high              <= RST_R0_HIGH;
      r1_low               <= RST_R1_LOW;
      r1_high              <= RST_R1_HIGH;
      range2               <= '{low: RST_R2_LOW, high: RST_R2_HIGH};
      range3               <= '{low: RST_R3_LOW, high: RST_R3_HIGH};
      event_mask           <= RST_EVENT_MASK;
    end else if (CLK_EN && wr_hit) begin
      unique case (REG_ADDR)
        OFS_CONTROL: begin
          ir_wake_control.proto  <= REG_WDATA[5:4];
          ir_wake_control.sel_b  <= REG_WDATA[3];
          ir_wake_control.invert <= REG_WDATA[2];
          ir_wake_control.enable <= REG_WDATA[0];
        end
        OFS_WAKE_ADDR:  ir_wake_address      <= REG_WDATA;
        OFS_ADDR_MASK:  ir_wake_address_mask <= REG_WDATA;
        OFS_R0_LOW:     r0_low               <= REG_WDATA[4:0];
        OFS_R0_HIGH:    r0_high              <= REG_WDATA[4:0];
        OFS_R1_LOW:     r1_low               <= REG_WDATA[4:0];
        OFS_R1_HIGH:    r1_high              <= REG_WDATA[4:0];
        OFS_R2_LOW:     range2.low           <= REG_WDATA;
        OFS_R2_HIGH:    range2.high          <= REG_WDATA;
        OFS_R3_LOW:     range3.low           <= REG_WDATA;
        OFS_R3_HIGH:    range3.high          <= REG_WDATA;
        OFS_EVENT_MASK: event_mask           <= REG_WDATA;
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise and when unmapped
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (CLK_EN) begin
      REG_RDATA <= 8'h00;
      if (REG_RD) begin
        unique case (REG_ADDR)
          OFS_CONTROL:      REG_RDATA <= {2'h0, ir_wake_control.proto, ir_wake_control.sel_b,
                                          ir_wake_control.invert, 1'b0, ir_wake_control.enable};
          OFS_WAKE_ADDR:    REG_RDATA <= ir_wake_address;
          OFS_ADDR_MASK:    REG_RDATA <= ir_wake_address_mask;
          OFS_RECV_ADDR:    REG_RDATA <= ir_received_address;
          OFS_R0_LOW:       REG_RDATA <= {3'h0, r0_low};
          OFS_R0_HIGH:      REG_RDATA <= {3'h0, r0_high};
          OFS_R1_LOW:       REG_RDATA <= {3'h0, r1_low};
          OFS_R1_HIGH:      REG_RDATA <= {3'h0, r1_high};
          OFS_R2_LOW:       REG_RDATA <= range2.low;
          OFS_R2_HIGH:      REG_RDATA <= range2.high;
          OFS_R3_LOW:       REG_RDATA <= range3.low;
          OFS_R3_HIGH:      REG_RDATA <= range3.high;
          OFS_EVENT_STATUS: REG_RDATA <= event_status;
          OFS_EVENT_MASK:   REG_RDATA <= event_mask;
          default:          REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule

/* File: hdl/irwd_pkg.sv */
// Purpose: shared constants and types of the infrared wake-up decoder
// Assumes: 8-bit register port, one 25 MHz clock
// Notes:   time limits are counts of 0.1 ms units
package irwd_pkg;

  // register offsets
  localparam logic [7:0] OFS_CONTROL      = 8'h13;
  localparam logic [7:0] OFS_WAKE_ADDR    = 8'h15;
  localparam logic [7:0] OFS_ADDR_MASK    = 8'h16;
  localparam logic [7:0] OFS_RECV_ADDR    = 8'h17;
  localparam logic [7:0] OFS_R0_LOW       = 8'h18;
  localparam logic [7:0] OFS_R0_HIGH      = 8'h19;
  localparam logic [7:0] OFS_R1_LOW       = 8'h1a;
  localparam logic [7:0] OFS_R1_HIGH      = 8'h1b;
  localparam logic [7:0] OFS_R2_LOW       = 8'h1c;
  localparam logic [7:0] OFS_R2_HIGH      = 8'h1d;
  localparam logic [7:0] OFS_R3_LOW       = 8'h1e;
  localparam logic [7:0] OFS_R3_HIGH      = 8'h1f;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h20;
  localparam logic [7:0] OFS_EVENT_MASK   = 8'h21;

  // reset values
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam logic [7:0] RST_WAKE_ADDR  = 8'h00;
  localparam logic [7:0] RST_ADDR_MASK  = 8'he0;
  localparam logic [7:0] RST_RECV_ADDR  = 8'h00;
  localparam logic [4:0] RST_R0_LOW     = 5'h10;
  localparam logic [4:0] RST_R0_HIGH    = 5'h14;
  localparam logic [4:0] RST_R1_LOW     = 5'h07;
  localparam logic [4:0] RST_R1_HIGH    = 5'h0b;
  localparam logic [7:0] RST_R2_LOW     = 8'h50;
  localparam logic [7:0] RST_R2_HIGH    = 8'h64;
  localparam logic [7:0] RST_R3_LOW     = 8'h28;
  localparam logic [7:0] RST_R3_HIGH    = 8'h32;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;

  // event status bit positions
  localparam int unsigned BIT_FRAME_DONE = 0;
  localparam int unsigned BIT_WAKE_MATCH = 5;

  // protocol select codes
  localparam logic [1:0] PROTO_BIPHASE  = 2'h0;
  localparam logic [1:0] PROTO_PULSEDIS = 2'h1;

  // frame geometry
  localparam logic [4:0] BIP_LAST_BIT   = 5'h0d;
  localparam logic [4:0] BIP_ADDR_FIRST = 5'h03;
  localparam logic [4:0] BIP_ADDR_LAST  = 5'h07;
  localparam logic [5:0] PD_ADDR_BITS   = 6'h08;
  localparam logic [5:0] PD_LAST_BIT    = 6'h1f;

  // timing: one limit unit is 0.1 ms
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TIME_UNIT_NS  = 100000;
  localparam int unsigned TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic [1:0] proto;
    logic       sel_b;
    logic       invert;
    logic       rsvd_lo;
    logic       enable;
  } irwd_ctrl_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } irwd_range_t;

endpackage

/* File: tb/ir_remote_wakeup_decoder_test.sv */
// Purpose: self-checking bench for the infrared wake-up decoder
// Assumes: one time unit shortened to four clock cycles
// Notes:   frames come from the remote model, results via register reads
`timescale 1ns/1ns
module ir_remote_wakeup_decoder_test;
  import irwd_pkg::*;
  localparam int unsigned TL = 4;
  logic       clock = 1'b0;
  logic       nrst = 1'b0;
  logic       clk_en = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       irq, wake_match, use_b = 1'b0, act_low = 1'b0;
  wire  logic line_a, line_b;
  int         fail_count = 0, checked = 0, hits = 0;

  irwd_decoder #(.TICK_LEN(TL)) dut_u (
    .CLOCK(clock), .NRST(nrst), .CLK_EN(clk_en), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IR_RECEIVE_INPUT_A(line_a),
    .IR_RECEIVE_INPUT_B(line_b), .IRQ(irq), .WAKE_MATCH(wake_match)
  );
  irwd_remote #(.TICK(TL)) rm (.clock(clock), .use_b(use_b), .act_low(act_low), .line_a(line_a), .line_b(line_b));

  initial forever #20 clock = ~clock;
  // pulses counted at the falling edge, where they are settled
  always @(negedge clock) hits += (wake_match === 1'b1);

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // writes leave a gap cycle in front so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, exp);
    @(posedge clock);
  endtask

  // long quiet gap first: reconfiguring can glitch a frame start
  task automatic frame(input logic [7:0] ctrl, input logic b, input logic pd, input logic [31:0] data,
                       input int unsigned half, input logic [7:0] st, input logic [7:0] rx);
    int h0;
    wr(OFS_CONTROL, ctrl);
    use_b <= b;
    act_low <= ctrl[2];
    repeat (270 * TL) @(posedge clock);
    h0 = hits;
    if (pd) rm.send_pd(data);
    else rm.send_bip(data[4:0], half);
    chk(8'(hits - h0), {7'h00, st[BIT_WAKE_MATCH]});
    rdc(OFS_EVENT_STATUS, st);
    chk({7'h00, irq}, {7'h00, st[BIT_WAKE_MATCH]});
    wr(OFS_EVENT_STATUS, 8'hff);
    rdc(OFS_RECV_ADDR, rx);
    chk({7'h00, irq}, 8'h00);
  endtask

  task automatic s_regs;
    rdc(OFS_CONTROL, 8'h00);
    rdc(OFS_ADDR_MASK, 8'he0);
    rdc(OFS_RECV_ADDR, 8'h00);
    rdc(OFS_R0_LOW, 8'h10);
    rdc(OFS_R0_HIGH, 8'h14);
    rdc(OFS_R1_LOW, 8'h07);
    rdc(OFS_R1_HIGH, 8'h0b);
    rdc(OFS_R2_LOW, 8'h50);
    rdc(OFS_R3_HIGH, 8'h32);
    rdc(8'h40, 8'h00);
    wr(OFS_RECV_ADDR, 8'h5a);
    rdc(OFS_RECV_ADDR, 8'h00);
    wr(OFS_CONTROL, 8'hff);
    rdc(OFS_CONTROL, 8'h3d);
    wr(OFS_R0_LOW, 8'hff);
    rdc(OFS_R0_LOW, 8'h1f);
    wr(OFS_R0_LOW, 8'h10);
    wr(OFS_EVENT_MASK, 8'h20);
  endtask

  // a miss sets only the frame bit, which the event mask hides
  task automatic s_bip;
    wr(OFS_WAKE_ADDR, 8'h0b);
    wr(OFS_ADDR_MASK, 8'he1);
    frame(8'h01, 1'b0, 1'b0, 32'h0a, 9, 8'h21, 8'h0a);
    frame(8'h01, 1'b0, 1'b0, 32'h09, 9, 8'h01, 8'h09);
    frame(8'h00, 1'b0, 1'b0, 32'h0b, 9, 8'h00, 8'h0b);
    frame(8'h0d, 1'b1, 1'b0, 32'h0b, 9, 8'h21, 8'h0b);
    frame(8'h0d, 1'b0, 1'b0, 32'h0a, 9, 8'h00, 8'h0b);
    frame(8'h01, 1'b0, 1'b0, 32'h0b, 13, 8'h00, 8'h00);
    frame(8'h21, 1'b0, 1'b0, 32'h0b, 9, 8'h00, 8'h00);
  endtask

  task automatic s_pd;
    wr(OFS_R0_LOW, 8'h09);
    wr(OFS_R0_HIGH, 8'h0d);
    wr(OFS_R1_LOW, 8'h14);
    wr(OFS_R1_HIGH, 8'h19);
    wr(OFS_WAKE_ADDR, 8'ha5);
    wr(OFS_ADDR_MASK, 8'h00);
    frame(8'h11, 1'b0, 1'b1, 32'h00ff_5aa5, 9, 8'h21, 8'ha5);
    frame(8'h11, 1'b0, 1'b1, 32'h00ff_5b25, 9, 8'h01, 8'h25);
  endtask

  // a write while the block is frozen must leave no trace
  task automatic s_hold;
    clk_en <= 1'b0;
    wr(OFS_WAKE_ADDR, 8'h3c);
    clk_en <= 1'b1;
    rdc(OFS_WAKE_ADDR, 8'ha5);
  endtask

  // hardware reset on NRST in mid-run brings back the reset values of the registers read
  task automatic s_reset;
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    rdc(OFS_CONTROL, 8'h00);
    rdc(OFS_ADDR_MASK, 8'he0);
    rdc(OFS_RECV_ADDR, 8'h00);
    rdc(OFS_R0_LOW, 8'h10);
    rdc(OFS_R1_HIGH, 8'h0b);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    s_regs();
    s_bip();
    s_pd();
    s_hold();
    s_reset();
    end_of_test();
  end

  // the whole run needs about 25000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
endmodule

bind irwd_decoder irwd_chk chk_u (
  .CLOCK, .NRST, .CLK_EN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
  .REG_RDATA, .IR_RECEIVE_INPUT_A, .IR_RECEIVE_INPUT_B, .IRQ, .WAKE_MATCH
);

/* File: tb/irwd_chk.sv */
// Purpose: port assertions for the infrared wake-up decoder
// Assumes: CLK_EN low only freezes the block
// Notes:   shadows follow software writes to control and event mask
`timescale 1ns/1ns
module irwd_chk
  import irwd_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       NRST,
  input wire logic       CLK_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       IR_RECEIVE_INPUT_A,
  input wire logic       IR_RECEIVE_INPUT_B,
  input wire logic       IRQ,
  input wire logic       WAKE_MATCH
);
  logic       en, sel_b, irq_en, ctrl_wr, mask_wr, pin_d;
  logic [7:0] quiet;
  wire  logic pin = sel_b ? IR_RECEIVE_INPUT_B : IR_RECEIVE_INPUT_A;

  // shadow of what software wrote since reset
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      {en, sel_b, irq_en, ctrl_wr, mask_wr} <= 5'h00;
    end else if (CLK_EN && REG_WR && REG_ADDR == OFS_CONTROL) begin
      {en, sel_b, ctrl_wr} <= {REG_WDATA[0], REG_WDATA[3], 1'b1};
    end else if (CLK_EN && REG_WR && REG_ADDR == OFS_EVENT_MASK) begin
      irq_en <= REG_WDATA[BIT_WAKE_MATCH];
    end else if (CLK_EN && REG_WR && REG_ADDR == OFS_ADDR_MASK) begin
      mask_wr <= 1'b1;
    end
  end

  // cycles since the selected pin moved; a match can only follow an edge
  always_ff @(posedge CLOCK) begin
    pin_d <= pin;
    if (!NRST) begin
      quiet <= 8'hff;
    end else if (pin != pin_d) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hff) begin
      quiet <= quiet + 8'h01;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST || !CLK_EN);

  AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data not zero outside a read");
  AST_CTRL_RST: assert property (REG_RD && REG_ADDR == OFS_CONTROL && !ctrl_wr |=> REG_RDATA == 8'h00)
    else $error("control not zero after reset");
  AST_MASK_RST: assert property (REG_RD && REG_ADDR == OFS_ADDR_MASK && !mask_wr |=> REG_RDATA == 8'he0)
    else $error("address mask not e0 after reset");
  AST_CTRL_RB: assert property ((REG_WR && REG_ADDR == OFS_CONTROL ##1 REG_RD && REG_ADDR == OFS_CONTROL)
    |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h3d)) else $error("control readback wrong");
  AST_RANGE_RSVD: assert property (REG_RD && REG_ADDR[7:2] == 6'h06 |=> REG_RDATA[7:5] == 3'h0)
    else $error("range reserved bits not zero");
  AST_MATCH_EN: assert property (WAKE_MATCH |-> en)
    else $error("match while decoder disabled");
  AST_MATCH_EDGE: assert property (WAKE_MATCH |-> quiet <= 8'h08)
    else $error("match without edge on selected input");
  AST_MATCH_IRQ: assert property (WAKE_MATCH && irq_en |-> IRQ ##1 !WAKE_MATCH)
    else $error("unmasked match without interrupt or long pulse");

  COV_MATCH: cover property (WAKE_MATCH);
  COV_IRQ_CLEAR: cover property (IRQ ##1 !IRQ);
  COV_RECV_READ: cover property (REG_RD && REG_ADDR == OFS_RECV_ADDR);
endmodule

/* File: tb/irwd_remote.sv */
// Purpose: remote control transmitter seen through a receiver module
// Assumes: tick is the decoder time unit in clock cycles
// Notes:   act_low flips both lines, as an inverting receiver would
`timescale 1ns/1ns
module irwd_remote #(
  parameter int unsigned TICK = 4
) (
  input  wire logic clock,
  input  wire logic use_b,
  input  wire logic act_low,
  output wire logic line_a,
  output wire logic line_b
);
  logic burst = 1'b0;

  // the unused line rests at its inactive level, never floats
  assign line_a = (burst & !use_b) ^ act_low;
  assign line_b = (burst & use_b) ^ act_low;

  // hold one burst level for a number of time units
  task automatic hold(input logic b, input int unsigned units);
    burst <= b;
    repeat (units * TICK) @(posedge clock);
  endtask

  // bi-phase: two start ones, toggle, address msb first, command
  task automatic send_bip(input logic [4:0] addr, input int unsigned half);
    logic [13:0] bits;
    bits = {3'b110, addr, 6'h2a};
    for (int i = 13; i >= 0; i--) begin
      hold(!bits[i], half);
      hold(bits[i], half);
    end
    hold(1'b0, 4);
  endtask

  // pulse-distance: header, gap, 32 bits lsb first, stop pulse
  task automatic send_pd(input logic [31:0] data);
    hold(1'b1, 90);
    hold(1'b0, 45);
    for (int i = 0; i < 32; i++) begin
      hold(1'b1, 5);
      hold(1'b0, data[i] ? 17 : 6);
    end
    hold(1'b1, 5);
    hold(1'b0, 4);
  endtask
endmodule
